// ===== verilog/rcsr_pkg.sv
// Package of constants for the reset-cause status register block
// Functional notes
// - A trap-conflict reset sets bit 15; a software write can also set it.
// - An illegal opcode, illegal address mode or uninitialised pointer reset sets bit 14.
// - Bits 13 down to 10 always read as zero.
// - A configuration-mismatch reset sets bit 9.
// - Bit 8 set keeps the regulator active in Sleep; clear puts it in standby during Sleep.
// - A master-clear pin reset sets bit 7.
// - Execution of a reset instruction sets bit 6.
// - Bit 5 is the software watchdog enable: one enables, zero disables.
// - With the watchdog fuse enable at one the watchdog is always on, ignoring bit 5.
// - A watchdog time-out sets bit 4.
// - Having been in Sleep sets bit 3.
// - Having been in Idle sets bit 2.
// - Software can set and clear every flag, and a set by software causes no reset.
package rcsr_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_IRQ_ST = 4'h4;
    localparam logic [3:0] ADDR_IRQ_MSK = 4'h8;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_TRAP = 15;
    localparam int BIT_IOP = 14;
    localparam int BIT_CM = 9;
    localparam int BIT_VREG = 8;
    localparam int BIT_PIN = 7;
    localparam int BIT_INSTR = 6;
    localparam int BIT_WDEN = 5;
    localparam int BIT_WATCHDOG_TIMEOUT_FLAG = 4;
    localparam int BIT_SLEEP = 3;
    localparam int BIT_IDLE = 2;
    localparam int BIT_BOR = 1;
    localparam int BIT_POR = 0;
    // Writable bits: all except the unimplemented 13..10
    localparam logic [15:0] WR_MASK = 16'hC3FF;
    // Value after power-on: power-on and brown-out flags set
    localparam logic [15:0] POR_VALUE = 16'h0003;
    // Bits that hardware events set
    localparam logic [15:0] EVT_MASK = 16'hC2DF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== verilog/rcsr_top.sv
// Reset-cause status register with AXI4-Lite access and event interrupt
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module rcsr_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    input  wire logic        por_n,
    input  wire logic        evt_trap,
    input  wire logic        evt_illegal_op,
    input  wire logic        evt_config_mismatch,
    input  wire logic        evt_master_clear_pin,
    input  wire logic        evt_reset_instr,
    input  wire logic        evt_wdt_timeout,
    input  wire logic        evt_sleep,
    input  wire logic        evt_idle,
    input  wire logic        evt_brownout,
    input  wire logic        watchdog_fuse_enable,
    output logic             watchdog_enable,
    output logic             regulator_sleep_active,
    output logic             irq,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // ****************************************
    // Event synchronisers
    // ****************************************
    // Events arrive from other reset/power logic, so each passes two flops
    logic [8:0]  evt_meta_q;
    logic [8:0]  evt_sync_q;
    logic [8:0]  evt_prev_q;
    logic [8:0]  evt_raw;
    logic [8:0]  evt_pulse;
    logic [15:0] evt_bits;
    logic [1:0]  fuse_meta_q;
    logic        fuse_q;

    // One lane per event source, no spare lane left constant
    assign evt_raw = {evt_trap, evt_illegal_op, evt_config_mismatch, evt_master_clear_pin,
                      evt_reset_instr, evt_wdt_timeout, evt_sleep, evt_idle,
                      evt_brownout};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_meta_q <= 9'h000;
            evt_sync_q <= 9'h000;
            evt_prev_q <= 9'h000;
            fuse_meta_q <= 2'h0;
            fuse_q <= 1'b0;
        end else if (clk_en) begin
            evt_meta_q <= evt_raw;
            evt_sync_q <= evt_meta_q;
            evt_prev_q <= evt_sync_q;
            fuse_meta_q <= {fuse_meta_q[0], watchdog_fuse_enable};
            fuse_q <= fuse_meta_q[1];
        end
    end

    // Rising edges only, so a held event line sets its flag once
    assign evt_pulse = evt_sync_q & ~evt_prev_q;

    // Map pulses onto status bit positions
    always_comb begin
        evt_bits = 16'h0000;
        evt_bits[rcsr_pkg::BIT_TRAP] = evt_pulse[8];
        evt_bits[rcsr_pkg::BIT_IOP] = evt_pulse[7];
        evt_bits[rcsr_pkg::BIT_CM] = evt_pulse[6];
        evt_bits[rcsr_pkg::BIT_PIN] = evt_pulse[5];
        evt_bits[rcsr_pkg::BIT_INSTR] = evt_pulse[4];
        evt_bits[rcsr_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = evt_pulse[3];
        evt_bits[rcsr_pkg::BIT_SLEEP] = evt_pulse[2];
        evt_bits[rcsr_pkg::BIT_IDLE] = evt_pulse[1];
        evt_bits[rcsr_pkg::BIT_BOR] = evt_pulse[0];
    end

    // ****************************************
    // AXI4-Lite write path
    // ****************************************
    logic        aw_held_q;
    logic [3:0]  aw_addr_q;
    logic        w_held_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        wr_fire;

    // Readies drop while frozen, so no beat sees a handshake it cannot complete
    assign s_axi_awready = clk_en && !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready = clk_en && !w_held_q && !s_axi_bvalid;
    assign wr_fire = clk_en && aw_held_q && w_held_q && !s_axi_bvalid;

    // Address and data are taken in either order, then the write commits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_held_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Response follows the commit by one edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= rcsr_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (addr_ok(aw_addr_q)) ? rcsr_pkg::RESP_OKAY
                                                    : rcsr_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Merge bytes of a write into a 16-bit register under the strobes
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
        logic [15:0] v;
        v = old_v;
        if (strb[0]) v[7:0] = data[7:0];
        if (strb[1]) v[15:8] = data[15:8];
        return v;
    endfunction

    // Decode of the three mapped words
    function automatic logic addr_ok(input logic [3:0] a);
        return (a[3:2] != 2'h3) && (a[1:0] == 2'h0);
    endfunction

    // ****************************************
    // Reset cause status register
    // ****************************************
    logic [15:0] status_q;
    logic [15:0] status_wr;
    logic        status_we;
    logic        por_seen_q;

    assign status_we = wr_fire && (aw_addr_q == rcsr_pkg::ADDR_STATUS);
    assign status_wr = merge16(status_q, w_data_q, w_strb_q) & rcsr_pkg::WR_MASK;

    // The power-on seed is caught on the first clocked edge after power-on;
    // ordinary aresetn does not touch the register so causes survive it
    always_ff @(posedge aclk) begin
        if (!por_n) begin
            status_q <= rcsr_pkg::POR_VALUE;
            por_seen_q <= 1'b1;
        end else if (clk_en) begin
            por_seen_q <= 1'b0;
            // Software write first, hardware events OR on top so a set wins
            if (status_we) begin
                status_q <= status_wr | evt_bits;
            end else begin
                status_q <= status_q | evt_bits;
            end
        end
    end

    // Watchdog runs when the fuse forces it or software enables it
    assign watchdog_enable = fuse_q | status_q[rcsr_pkg::BIT_WDEN];
    assign regulator_sleep_active = status_q[rcsr_pkg::BIT_VREG];

    // ****************************************
    // Interrupt status and mask
    // ****************************************
    logic [15:0] irq_st_q;
    logic [15:0] irq_msk_q;
    logic        rd_status_clr;
    logic        ar_fire;

    assign ar_fire = clk_en && s_axi_arvalid && s_axi_arready;
    assign rd_status_clr = ar_fire && (s_axi_araddr == rcsr_pkg::ADDR_IRQ_ST);

    // Read clears the sticky bits, a new event in the same cycle survives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_st_q <= 16'h0000;
        end else if (clk_en) begin
            irq_st_q <= (rd_status_clr ? 16'h0000 : irq_st_q)
                        | ((evt_bits | {15'h0000, por_seen_q}) & rcsr_pkg::EVT_MASK);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_msk_q <= 16'h0000;
        end else if (clk_en && wr_fire && (aw_addr_q == rcsr_pkg::ADDR_IRQ_MSK)) begin
            irq_msk_q <= merge16(irq_msk_q, w_data_q, w_strb_q) & rcsr_pkg::EVT_MASK;
        end
    end

    // Level interrupt while any unmasked event bit stands
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(irq_st_q & irq_msk_q);
        end
    end

    // ****************************************
    // AXI4-Lite read path
    // ****************************************
    assign s_axi_arready = clk_en && !s_axi_rvalid;

    // Data registered one edge after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= rcsr_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (ar_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= rcsr_pkg::RESP_OKAY;
                case (s_axi_araddr)
                    rcsr_pkg::ADDR_STATUS: s_axi_rdata <= {16'h0000, status_q};
                    rcsr_pkg::ADDR_IRQ_ST: s_axi_rdata <= {16'h0000, irq_st_q};
                    rcsr_pkg::ADDR_IRQ_MSK: s_axi_rdata <= {16'h0000, irq_msk_q};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= rcsr_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// ===== tb/rcsr_chk.sv
// Port-level assertions for the reset-cause register block
`timescale 1ns/1ps
module rcsr_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        watchdog_fuse_enable,
    input wire logic        watchdog_enable,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    // One clock domain; the bus reset parks every check
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_rdata_unused: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0
        && s_axi_rdata[13:10] == 4'h0) else $error("unused read bits not zero");
    // Four samples cover the three flops between the fuse pin and the output
    a_fuse_on: assert property (watchdog_fuse_enable[*4] |-> watchdog_enable)
        else $error("fuse did not force watchdog on");
    a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read answer changed");
    a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    // Main traffic and a fuse rise seen at least once
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_fuse: cover property ($rose(watchdog_fuse_enable));
endmodule

bind rcsr_top rcsr_chk u_chk (
    .aclk, .aresetn, .watchdog_fuse_enable, .watchdog_enable, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata
);

// ===== tb/rcsr_top_tb.sv
// Self-checking bench for the reset-cause register block
`timescale 1ns/1ps
module rcsr_top_tb;
    logic        aclk = 1'b0, aresetn = 1'b0, por_n = 1'b0, watchdog_fuse_enable = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        watchdog_enable, regulator_sleep_active, irq, clk_en = 1'b1;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, qb[$];
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [8:0]  evt = 9'h0;
    logic [15:0] st;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [33:0] qr[$];
    int          errors, num_checks, k;
    int          pos[9] = '{15, 14, 9, 7, 6, 4, 3, 2, 1};

    rcsr_top dut (
        .aclk, .aresetn, .clk_en, .por_n, .evt_trap(evt[0]), .evt_illegal_op(evt[1]),
        .evt_config_mismatch(evt[2]), .evt_master_clear_pin(evt[3]), .evt_reset_instr(evt[4]),
        .evt_wdt_timeout(evt[5]), .evt_sleep(evt[6]), .evt_idle(evt[7]),
        .evt_brownout(evt[8]), .watchdog_fuse_enable, .watchdog_enable,
        .regulator_sleep_active, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );

    // 250 MHz clock
    initial begin
        forever #2 aclk = ~aclk;
    end

    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One transfer; the note goes on a queue, the monitor compares the answer
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [33:0] e);
        int n;
        @(posedge aclk);
        if (w) qb.push_back(e[33:32]);
        else qr.push_back(e);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) break;
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (n == 40) begin
            errors++;
            print_verdict();
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, {rcsr_pkg::RESP_OKAY, 32'h0});
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, {rcsr_pkg::RESP_OKAY, e});
    endtask

    // One-cycle event pulse, then room for the synchroniser
    task automatic pulse(input int i);
        @(posedge aclk);
        evt[i] <= 1'b1;
        @(posedge aclk);
        evt <= 9'h0;
        repeat (5) @(posedge aclk);
    endtask

    task automatic rst(input logic p);
        aresetn <= 1'b0;
        por_n <= p;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        por_n <= 1'b1;
    endtask

    task automatic irqc(input logic e);
        repeat (3) @(posedge aclk);
        chk("irq", {33'h0, irq}, {33'h0, e});
    endtask

    // Each answer is matched against the oldest note of its kind
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready)
            chk("bresp", {32'h0, s_axi_bresp}, {32'h0, qb.pop_front()});
        if (s_axi_rvalid && s_axi_rready)
            chk("read", {s_axi_rresp, s_axi_rdata}, qr.pop_front());
    end

    initial begin
        k = $urandom(44);
        rst(1'b0);
        rd(rcsr_pkg::ADDR_STATUS, 32'h0000_0003);
        wr(rcsr_pkg::ADDR_STATUS, 32'h0);
        st = 16'h0;
        for (k = 0; k < 9; k++) begin
            pulse(k);
            st[pos[k]] = 1'b1;
            rd(rcsr_pkg::ADDR_STATUS, {16'h0, st});
        end
        $display("causes done");
        for (k = 0; k < 5; k++) begin
            st = (k == 0) ? 16'hFFFF : 16'($urandom());
            wr(rcsr_pkg::ADDR_STATUS, {16'h0, st});
            rd(rcsr_pkg::ADDR_STATUS, {16'h0, st & 16'hC3FF});
            chk("vreg", {33'h0, regulator_sleep_active}, {33'h0, st[8]});
            chk("wden", {33'h0, watchdog_enable}, {33'h0, st[5]});
        end
        // Low byte lane only: the upper byte keeps its value
        s_axi_wstrb <= 4'h1;
        wr(rcsr_pkg::ADDR_STATUS, 32'h0);
        rd(rcsr_pkg::ADDR_STATUS, {16'h0, st & 16'hC300});
        s_axi_wstrb <= 4'hF;
        wr(rcsr_pkg::ADDR_STATUS, 32'h0);
        watchdog_fuse_enable <= 1'b1;
        repeat (4) @(posedge aclk);
        chk("fuse", {33'h0, watchdog_enable}, 34'h1);
        watchdog_fuse_enable <= 1'b0;
        pulse(0);
        rst(1'b1);
        rd(rcsr_pkg::ADDR_STATUS, 32'h0000_8000);
        rst(1'b0);
        rd(rcsr_pkg::ADDR_STATUS, 32'h0000_0003);
        $display("software and keep done");
        rd(rcsr_pkg::ADDR_IRQ_ST, 32'h0000_0001);
        rd(rcsr_pkg::ADDR_IRQ_ST, 32'h0);
        wr(rcsr_pkg::ADDR_IRQ_MSK, 32'hFFFF_FFFF);
        rd(rcsr_pkg::ADDR_IRQ_MSK, 32'h0000_C2DF);
        irqc(1'b0);
        pulse(5);
        irqc(1'b1);
        wr(rcsr_pkg::ADDR_IRQ_MSK, 32'h0);
        irqc(1'b0);
        wr(rcsr_pkg::ADDR_IRQ_MSK, 32'h0000_0010);
        irqc(1'b1);
        rd(rcsr_pkg::ADDR_IRQ_ST, 32'h0000_0010);
        irqc(1'b0);
        $display("interrupt done");
        bus(1'b0, 4'hC, 32'h0, {rcsr_pkg::RESP_SLVERR, 32'h0});
        bus(1'b1, 4'hC, 32'hFFFF_FFFF, {rcsr_pkg::RESP_SLVERR, 32'h0});
        bus(1'b1, 4'h1, 32'hFFFF_FFFF, {rcsr_pkg::RESP_SLVERR, 32'h0});
        rd(rcsr_pkg::ADDR_STATUS, 32'h0000_0013);
        $display("unmapped done");
        // A frozen block misses an event that comes and goes while it is held
        clk_en <= 1'b0;
        pulse(6);
        clk_en <= 1'b1;
        rd(rcsr_pkg::ADDR_STATUS, 32'h0000_0013);
        $display("enable done");
        print_verdict();
    end
endmodule
